// ==== rdq_defs.svh ====
// constants for the redriver equalization and mode configuration block
`ifndef RDQ_DEFS_SVH
`define RDQ_DEFS_SVH

`define RDQ_CLK_MHZ          100
`define RDQ_SWEEP_TIME_US    400
`define RDQ_QUICK_TIME_US    60
`define RDQ_STRAP_PINS       5
`define RDQ_EQ_W             4
`define RDQ_SCORE_W          8
`define RDQ_CNT_W            16
`define RDQ_EQ_MAX           4'hf
`define RDQ_EQ_RST           4'h0
`define RDQ_SWEEP_UPPER_DEF  4'h8
`define RDQ_QUICK_SHORT_EQ   4'h2
`define RDQ_QUICK_LONG_EQ    4'h9
`define RDQ_LVL_W            2
`define RDQ_PIN_HOST_LO      0
`define RDQ_PIN_HOST_HI      1
`define RDQ_PIN_CONN_LO      2
`define RDQ_PIN_CONN_HI      3
`define RDQ_PIN_MODE         4

`endif

// ==== rdq_pkg.sv ====
// types shared by the redriver equalization configuration modules
`default_nettype none
package rdq_pkg;
	typedef enum logic [1:0] {
		RDQ_LVL_0 = 2'h0,
		RDQ_LVL_R = 2'h1,
		RDQ_LVL_F = 2'h2,
		RDQ_LVL_1 = 2'h3
	} rdq_level_t;
	typedef enum logic [1:0] {
		RDQ_EQ_FIXED,
		RDQ_EQ_QUICK,
		RDQ_EQ_SWEEP
	} rdq_eq_mode_t;
endpackage
`default_nettype wire

// ==== rdq_strap_decode.sv ====
// four-level strap decoder: comparator thermometer codes to two-bit symbols
`default_nettype none
`include "rdq_defs.svh"
module rdq_strap_decode (
	// comparator outputs, three thresholds per pin
	input  wire logic [`RDQ_STRAP_PINS-1:0][2:0]            i_therm,
	// decoded symbols 0, R, F, 1 as 0..3
	output var  logic [`RDQ_STRAP_PINS-1:0][`RDQ_LVL_W-1:0] o_level
);
	import rdq_pkg::*;

	// a broken thermometer code can only come from a floating pin mid-settle,
	// so it is read as F rather than guessed
	function automatic rdq_level_t therm_to_level(input logic [2:0] t);
		unique case (t)
			3'h0:    therm_to_level = RDQ_LVL_0;
			3'h1:    therm_to_level = RDQ_LVL_R;
			3'h3:    therm_to_level = RDQ_LVL_F;
			3'h7:    therm_to_level = RDQ_LVL_1;
			default: therm_to_level = RDQ_LVL_F;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < `RDQ_STRAP_PINS; g++) begin : g_pin
			always_comb begin
				o_level[g] = therm_to_level(i_therm[g]);
			end
		end
	endgenerate
endmodule // rdq_strap_decode
`default_nettype wire

// ==== rdq_adapt_engine.sv ====
// adaptive equalization engine for one connector-facing receiver
`default_nettype none
`include "rdq_defs.svh"
module rdq_adapt_engine #(
	parameter int unsigned STEP_CYCLES  = 2000,
	parameter int unsigned QUICK_CYCLES = 5000
) (
	input  wire logic                      i_clock,
	input  wire logic                      i_rst,
	// configuration
	input  wire logic                      i_run,
	input  wire rdq_pkg::rdq_eq_mode_t     i_mode,
	input  wire logic [`RDQ_EQ_W-1:0]      i_fixed_eq,
	input  wire logic [`RDQ_EQ_W-1:0]      i_upper,
	input  wire logic [`RDQ_EQ_W-1:0]      i_offset_amount,
	input  wire logic                      i_offset_direction,
	// channel observations
	input  wire logic                      i_insert,
	input  wire logic [`RDQ_SCORE_W-1:0]   i_eye_score,
	input  wire logic                      i_long_channel,
	// result
	output var  logic [`RDQ_EQ_W-1:0]      o_eq,
	output var  logic                      o_busy
);
	import rdq_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SWEEP, ST_QUICK} rdq_eng_state_t;
	localparam logic [`RDQ_CNT_W-1:0] STEP_LAST  = `RDQ_CNT_W'(STEP_CYCLES - 1);
	localparam logic [`RDQ_CNT_W-1:0] QUICK_LAST = `RDQ_CNT_W'(QUICK_CYCLES - 1);

	rdq_eng_state_t            state_q, state_d;
	logic [`RDQ_CNT_W-1:0]     cnt_q, cnt_d;
	logic [`RDQ_EQ_W-1:0]      cand_q, cand_d, best_q, best_d, eq_q, eq_d;
	logic [`RDQ_SCORE_W-1:0]   score_q, score_d;

	// offset applied after the sweep; subtraction floors at zero
	function automatic logic [`RDQ_EQ_W-1:0] apply_offset(input logic [`RDQ_EQ_W-1:0] b,
			input logic [`RDQ_EQ_W-1:0] amt, input logic dir);
		logic [`RDQ_EQ_W:0] s;
		s = {1'b0, b} + {1'b0, amt};
		if (dir)
			apply_offset = (amt > b) ? `RDQ_EQ_RST : b - amt;
		else
			apply_offset = (s > {1'b0, `RDQ_EQ_MAX}) ? `RDQ_EQ_MAX : s[`RDQ_EQ_W-1:0];
	endfunction

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		cand_d  = cand_q;
		best_d  = best_q;
		score_d = score_q;
		eq_d    = eq_q;
		if (!i_run) begin
			state_d = ST_IDLE;
			cnt_d   = '0;
			cand_d  = '0;
			best_d  = '0;
			score_d = '0;
			eq_d    = `RDQ_EQ_RST;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (i_mode == RDQ_EQ_FIXED)
						eq_d = i_fixed_eq;
					if (i_insert && i_mode == RDQ_EQ_SWEEP) begin
						state_d = ST_SWEEP;
						cnt_d   = '0;
						cand_d  = '0;
						best_d  = '0;
						score_d = '0;
					end else if (i_insert && i_mode == RDQ_EQ_QUICK) begin
						state_d = ST_QUICK;
						cnt_d   = '0;
					end
				end
				ST_SWEEP: begin
					cnt_d = cnt_q + 1'b1;
					if (i_mode != RDQ_EQ_SWEEP) begin
						state_d = ST_IDLE;
					end else if (cnt_q == STEP_LAST) begin
						cnt_d = '0;
						// strict compare keeps the lowest index on a tie
						if (cand_q == '0 || i_eye_score > score_q) begin
							best_d  = cand_q;
							score_d = i_eye_score;
						end
						if (cand_q >= i_upper) begin
							eq_d    = apply_offset(best_d, i_offset_amount, i_offset_direction);
							state_d = ST_IDLE;
						end else begin
							cand_d = cand_q + 1'b1;
						end
					end
				end
				ST_QUICK: begin
					cnt_d = cnt_q + 1'b1;
					if (i_mode != RDQ_EQ_QUICK) begin
						state_d = ST_IDLE;
					end else if (cnt_q == QUICK_LAST) begin
						eq_d    = i_long_channel ? `RDQ_QUICK_LONG_EQ : `RDQ_QUICK_SHORT_EQ;
						state_d = ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			cand_q  <= '0;
			best_q  <= '0;
			score_q <= '0;
			eq_q    <= `RDQ_EQ_RST;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			cand_q  <= cand_d;
			best_q  <= best_d;
			score_q <= score_d;
			eq_q    <= eq_d;
		end
	end

	// the receiver runs the trial setting while sweeping
	always_comb begin
		o_eq   = (state_q == ST_SWEEP) ? cand_q : eq_q;
		o_busy = (state_q != ST_IDLE);
	end
endmodule // rdq_adapt_engine
`default_nettype wire

// ==== rdq_config.sv ====
// strap latch, register override and equalization mode control for the redriver
`default_nettype none
`include "rdq_defs.svh"

module rdq_config #(
	parameter int unsigned SWEEP_DONE_CYCLES = `RDQ_SWEEP_TIME_US * `RDQ_CLK_MHZ,
	parameter int unsigned QUICK_DONE_CYCLES = `RDQ_QUICK_TIME_US * `RDQ_CLK_MHZ
) (
	// clock and reset
	input  wire logic                                 i_clock,
	input  wire logic                                 i_rst,
	// enable pin and strap comparators
	input  wire logic                                 i_enable,
	input  wire logic [`RDQ_STRAP_PINS-1:0][2:0]      i_strap_therm,
	// register-mode configuration
	input  wire logic                                 i_reg_mode,
	input  wire logic [`RDQ_EQ_W-1:0]                 i_reg_host_eq,
	input  wire logic [`RDQ_EQ_W-1:0]                 i_reg_conn_a_eq,
	input  wire logic [`RDQ_EQ_W-1:0]                 i_reg_conn_b_eq,
	input  wire logic [1:0]                           i_reg_conn_mode,
	input  wire logic [`RDQ_EQ_W-1:0]                 i_reg_sweep_upper_limit,
	input  wire logic [`RDQ_EQ_W-1:0]                 i_reg_eq_offset_amount,
	input  wire logic                                 i_reg_eq_offset_direction,
	input  wire logic                                 i_reg_limited_enable,
	input  wire logic [1:0]                           i_reg_preshoot,
	input  wire logic [1:0]                           i_reg_deemphasis,
	// connector receiver observations
	input  wire logic                                 i_insert_a,
	input  wire logic                                 i_insert_b,
	input  wire logic [`RDQ_SCORE_W-1:0]              i_eye_score_a,
	input  wire logic [`RDQ_SCORE_W-1:0]              i_eye_score_b,
	input  wire logic                                 i_long_channel_a,
	input  wire logic                                 i_long_channel_b,
	// strap status
	output logic                                      o_strap_bias_off,
	output logic                                      o_straps_valid,
	// equalization settings
	output logic [`RDQ_EQ_W-1:0]                      o_host_side_receiver_eq,
	output logic [`RDQ_EQ_W-1:0]                      o_connector_rx_port_a_eq,
	output logic [`RDQ_EQ_W-1:0]                      o_connector_rx_port_b_eq,
	output logic [1:0]                                o_connector_eq_mode,
	output logic                                      o_adapt_busy_a,
	output logic                                      o_adapt_busy_b,
	// transmitter modes
	output logic                                      o_host_to_conn_linear,
	output logic                                      o_host_side_transmitter_limited,
	output logic [1:0]                                o_preshoot,
	output logic [1:0]                                o_deemphasis
);
	import rdq_pkg::*;

	// sweep step leaves margin for the apply cycle and the output register
	localparam int unsigned STEP_CYCLES  = (SWEEP_DONE_CYCLES - 8) / 16;
	localparam int unsigned QUICK_CYCLES = QUICK_DONE_CYCLES - 4;

	// strap symbol 1 and register code 3 fall back to fixed, the safe choice
	function automatic rdq_eq_mode_t decode_mode(input logic [1:0] code);
		unique case (code)
			2'h1:    decode_mode = RDQ_EQ_QUICK;
			2'h2:    decode_mode = RDQ_EQ_SWEEP;
			default: decode_mode = RDQ_EQ_FIXED;
		endcase
	endfunction

	// ---- strap sampling
	logic [`RDQ_STRAP_PINS-1:0][`RDQ_LVL_W-1:0] level;
	logic [`RDQ_STRAP_PINS-1:0][`RDQ_LVL_W-1:0] strap_q, strap_d;
	logic                                       en_q, en_d;
	logic                                       valid_q, valid_d;
	logic                                       bias_q, bias_d;

	rdq_strap_decode u_decode (
		.i_therm (i_strap_therm),
		.o_level (level)
	);

	always_comb begin
		en_d    = i_enable;
		strap_d = strap_q;
		valid_d = valid_q;
		bias_d  = bias_q;
		if (!i_enable) begin
			strap_d = '0;
			valid_d = 1'b0;
			bias_d  = 1'b0;
		end else if (!en_q) begin
			strap_d = level;
			valid_d = 1'b1;
		end else if (valid_q) begin
			bias_d = 1'b1;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			en_q    <= 1'b0;
			strap_q <= '0;
			valid_q <= 1'b0;
			bias_q  <= 1'b0;
		end else begin
			en_q    <= en_d;
			strap_q <= strap_d;
			valid_q <= valid_d;
			bias_q  <= bias_d;
		end
	end

	// ---- source selection
	logic [`RDQ_EQ_W-1:0] host_eq, conn_a_eq, conn_b_eq, strap_host_eq, strap_conn_eq;
	logic [`RDQ_EQ_W-1:0] upper, offset_amount;
	logic                 offset_direction;
	rdq_eq_mode_t         conn_mode;

	always_comb begin
		strap_host_eq = {strap_q[`RDQ_PIN_HOST_HI], strap_q[`RDQ_PIN_HOST_LO]};
		strap_conn_eq = {strap_q[`RDQ_PIN_CONN_HI], strap_q[`RDQ_PIN_CONN_LO]};
		if (i_reg_mode) begin
			host_eq          = i_reg_host_eq;
			conn_a_eq        = i_reg_conn_a_eq;
			conn_b_eq        = i_reg_conn_b_eq;
			conn_mode        = decode_mode(i_reg_conn_mode);
			upper            = i_reg_sweep_upper_limit;
			offset_amount    = i_reg_eq_offset_amount;
			offset_direction = i_reg_eq_offset_direction;
		end else begin
			host_eq          = strap_host_eq;
			conn_a_eq        = strap_conn_eq;
			conn_b_eq        = strap_conn_eq;
			conn_mode        = decode_mode(strap_q[`RDQ_PIN_MODE]);
			upper            = `RDQ_SWEEP_UPPER_DEF;
			offset_amount    = `RDQ_EQ_RST;
			offset_direction = 1'b0;
		end
	end

	// ---- adaptive engines, one per connector receiver
	logic [1:0]                        insert, long_ch, busy;
	logic [1:0][`RDQ_SCORE_W-1:0]      score;
	logic [1:0][`RDQ_EQ_W-1:0]         fixed_eq, eng_eq;

	always_comb begin
		insert   = {i_insert_b, i_insert_a};
		long_ch  = {i_long_channel_b, i_long_channel_a};
		score    = {i_eye_score_b, i_eye_score_a};
		fixed_eq = {conn_b_eq, conn_a_eq};
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_port
			rdq_adapt_engine #(
				.STEP_CYCLES  (STEP_CYCLES),
				.QUICK_CYCLES (QUICK_CYCLES)
			) u_engine (
				.i_clock            (i_clock),
				.i_rst              (i_rst),
				.i_run              (valid_q),
				.i_mode             (conn_mode),
				.i_fixed_eq         (fixed_eq[g]),
				.i_upper            (upper),
				.i_offset_amount    (offset_amount),
				.i_offset_direction (offset_direction),
				.i_insert           (insert[g]),
				.i_eye_score        (score[g]),
				.i_long_channel     (long_ch[g]),
				.o_eq               (eng_eq[g]),
				.o_busy             (busy[g])
			);
		end
	endgenerate

	// ---- registered outputs
	logic [`RDQ_EQ_W-1:0] host_q, host_d, a_q, a_d, b_q, b_d;
	logic [1:0]           mode_q, mode_d, pre_q, pre_d, de_q, de_d;
	logic                 lim_q, lim_d, busy_a_q, busy_a_d, busy_b_q, busy_b_d, lin_q, lin_d;

	always_comb begin
		host_d   = host_eq;
		a_d      = eng_eq[0];
		b_d      = eng_eq[1];
		mode_d   = conn_mode;
		busy_a_d = busy[0];
		busy_b_d = busy[1];
		lin_d    = 1'b1;
		lim_d    = i_reg_mode & i_reg_limited_enable;
		pre_d    = lim_d ? i_reg_preshoot : 2'h0;
		de_d     = lim_d ? i_reg_deemphasis : 2'h0;
		if (!valid_q) begin
			host_d = `RDQ_EQ_RST;
			mode_d = RDQ_EQ_FIXED;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			host_q   <= `RDQ_EQ_RST;
			a_q      <= `RDQ_EQ_RST;
			b_q      <= `RDQ_EQ_RST;
			mode_q   <= RDQ_EQ_FIXED;
			busy_a_q <= 1'b0;
			busy_b_q <= 1'b0;
			lin_q    <= 1'b1;
			lim_q    <= 1'b0;
			pre_q    <= 2'h0;
			de_q     <= 2'h0;
		end else begin
			host_q   <= host_d;
			a_q      <= a_d;
			b_q      <= b_d;
			mode_q   <= mode_d;
			busy_a_q <= busy_a_d;
			busy_b_q <= busy_b_d;
			lin_q    <= lin_d;
			lim_q    <= lim_d;
			pre_q    <= pre_d;
			de_q     <= de_d;
		end
	end

	always_comb begin
		o_strap_bias_off                = bias_q;
		o_straps_valid                  = valid_q;
		o_host_side_receiver_eq         = host_q;
		o_connector_rx_port_a_eq        = a_q;
		o_connector_rx_port_b_eq        = b_q;
		o_connector_eq_mode             = mode_q;
		o_adapt_busy_a                  = busy_a_q;
		o_adapt_busy_b                  = busy_b_q;
		o_host_to_conn_linear           = lin_q;
		o_host_side_transmitter_limited = lim_q;
		o_preshoot                      = pre_q;
		o_deemphasis                    = de_q;
	end
endmodule // rdq_config
`default_nettype wire

// ==== rdq_config_checker.sv ====
// assertion checker for the redriver equalization configuration block
`default_nettype none
module rdq_config_checker #(
	parameter int unsigned SWEEP_DONE_CYCLES = 200,
	parameter int unsigned QUICK_DONE_CYCLES = 20
) (
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic       i_enable,
	input wire logic       i_reg_mode,
	input wire logic       i_reg_limited_enable,
	input wire logic [1:0] i_reg_preshoot,
	input wire logic       i_insert_a,
	input wire logic       o_straps_valid,
	input wire logic       o_strap_bias_off,
	input wire logic [3:0] o_host_side_receiver_eq,
	input wire logic [3:0] o_connector_rx_port_a_eq,
	input wire logic [1:0] o_connector_eq_mode,
	input wire logic       o_adapt_busy_a,
	input wire logic       o_host_to_conn_linear,
	input wire logic       o_host_side_transmitter_limited,
	input wire logic [1:0] o_preshoot
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SWEEP_LIM = SWEEP_DONE_CYCLES;
	localparam int QUICK_LIM = QUICK_DONE_CYCLES;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_linear; o_host_to_conn_linear; endproperty
	a_linear: assert property (p_linear) else $error("host to connector path left linear mode");
	property p_capture; $rose(i_enable) |=> o_straps_valid; endproperty
	a_capture: assert property (p_capture) else $error("straps not latched after enable rise");
	property p_bias; $rose(o_straps_valid) |=> o_strap_bias_off; endproperty
	a_bias: assert property (p_bias) else $error("strap bias still connected after sampling");
	property p_clear; !i_enable |=> !o_straps_valid; endproperty
	a_clear: assert property (p_clear) else $error("latched straps kept while enable low");
	property p_host_zero; !o_straps_valid |=> o_host_side_receiver_eq == 4'h0; endproperty
	a_host_zero: assert property (p_host_zero) else $error("host eq not at default before latch");
	property p_lim_off; !i_reg_mode |=> !o_host_side_transmitter_limited; endproperty
	a_lim_off: assert property (p_lim_off) else $error("limited mode without register enable");
	property p_lim_on;
		i_reg_mode && i_reg_limited_enable |=> o_host_side_transmitter_limited && o_preshoot == $past(i_reg_preshoot);
	endproperty
	a_lim_on: assert property (p_lim_on) else $error("limited mode or preshoot not applied");
	property p_sweep_start; $rose(o_adapt_busy_a) && o_connector_eq_mode == 2'h2 |-> o_connector_rx_port_a_eq == 4'h0; endproperty
	a_sweep_start: assert property (p_sweep_start) else $error("sweep did not start at index zero");
	property p_sweep_time; $rose(o_adapt_busy_a) && o_connector_eq_mode == 2'h2 |-> ##[1:SWEEP_LIM] !o_adapt_busy_a; endproperty
	a_sweep_time: assert property (p_sweep_time) else $error("sweep search overran its time");
	property p_quick_time; $rose(o_adapt_busy_a) && o_connector_eq_mode == 2'h1 |-> ##[1:QUICK_LIM] !o_adapt_busy_a; endproperty
	a_quick_time: assert property (p_quick_time) else $error("quick decision overran its time");
	property p_take;
		i_enable && o_straps_valid && i_insert_a && !o_adapt_busy_a && o_connector_eq_mode != 2'h0 |=> ##1 o_adapt_busy_a;
	endproperty
	a_take: assert property (p_take) else $error("insertion did not start adaptation");
	cp_sweep: cover property ($rose(o_adapt_busy_a) && o_connector_eq_mode == 2'h2);
	cp_quick: cover property ($rose(o_adapt_busy_a) && o_connector_eq_mode == 2'h1);
	cp_limited: cover property ($rose(o_host_side_transmitter_limited));
endmodule // rdq_config_checker
bind rdq_config rdq_config_checker #(.SWEEP_DONE_CYCLES(SWEEP_DONE_CYCLES), .QUICK_DONE_CYCLES(QUICK_DONE_CYCLES)) u_chk (
	.i_clock, .i_rst, .i_enable, .i_reg_mode, .i_reg_limited_enable, .i_reg_preshoot, .i_insert_a,
	.o_straps_valid, .o_strap_bias_off, .o_host_side_receiver_eq, .o_connector_rx_port_a_eq,
	.o_connector_eq_mode, .o_adapt_busy_a, .o_host_to_conn_linear, .o_host_side_transmitter_limited, .o_preshoot
);
`default_nettype wire

// ==== rdq_strap_board.sv ====
// board strap model: resistor levels as seen through the pin comparators
`default_nettype none
module rdq_strap_board (
	input  wire logic            i_clock,
	input  wire logic [4:0][1:0] i_level,
	input  wire logic            i_bias_off,
	output var  logic [4:0][2:0] o_therm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wander_q = 3'h5;
	always @(posedge i_clock) wander_q <= wander_q + 3'h3;
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			case (i_level[p])
				2'h0: o_therm[p] = 3'h0;
				2'h1: o_therm[p] = 3'h1;
				2'h2: o_therm[p] = 3'h3;
				default: o_therm[p] = 3'h7;
			endcase
			// isolated pins no longer see the divider, so the reading wanders
			if (i_bias_off) o_therm[p] = wander_q ^ 3'(p);
		end
	end
endmodule // rdq_strap_board
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the redriver equalization configuration block
`default_nettype none
`include "rdq_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 0, i_rst = 1, i_enable = 0, i_reg_mode = 0, i_reg_eq_offset_direction = 0;
	logic i_reg_limited_enable = 0, i_insert_a = 0, i_insert_b = 0, i_long_channel_a = 0, i_long_channel_b = 0;
	logic [3:0] i_reg_host_eq = 0, i_reg_conn_a_eq = 0, i_reg_conn_b_eq = 0, i_reg_sweep_upper_limit = 0;
	logic [3:0] i_reg_eq_offset_amount = 0, best_a = 0, best_b = 0, h, c;
	logic [1:0] i_reg_conn_mode = 0, i_reg_preshoot = 0, i_reg_deemphasis = 0;
	logic [7:0] i_eye_score_a = 0, i_eye_score_b = 0;
	logic [4:0][1:0] sym = '0;
	logic [4:0][2:0] therm;
	logic o_strap_bias_off, o_straps_valid, o_adapt_busy_a, o_adapt_busy_b, o_host_to_conn_linear;
	logic o_host_side_transmitter_limited;
	logic [3:0] o_host_side_receiver_eq, o_connector_rx_port_a_eq, o_connector_rx_port_b_eq;
	logic [1:0] o_connector_eq_mode, o_preshoot, o_deemphasis;
	int n_errors = 0, total_checks = 0, cycles = 0;
	rdq_config #(.SWEEP_DONE_CYCLES(200), .QUICK_DONE_CYCLES(20)) uut (.i_strap_therm(therm), .*);
	rdq_strap_board board (.i_clock(i_clock), .i_level(sym), .i_bias_off(o_strap_bias_off), .o_therm(therm));
	always #5 i_clock = ~i_clock;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			end_of_test();
		end
	end
	function automatic logic [7:0] score(input logic [3:0] idx, input logic [3:0] best);
		return 8'hf0 - 8'((idx > best ? idx - best : best - idx) * 8);
	endfunction
	function automatic logic [3:0] expect_eq(input logic [1:0] md, input logic [3:0] best, input logic lng);
		int v;
		if (md == 2'h1) return lng ? `RDQ_QUICK_LONG_EQ : `RDQ_QUICK_SHORT_EQ;
		v = i_reg_eq_offset_direction ? int'(best) - int'(i_reg_eq_offset_amount) : int'(best) + int'(i_reg_eq_offset_amount);
		return (v > 15) ? 4'hf : (v < 0) ? 4'h0 : 4'(v);
	endfunction
	// trial quality peaks at the hidden best index of each port
	always @(posedge i_clock) begin
		#1;
		i_eye_score_a = score(o_connector_rx_port_a_eq, best_a);
		i_eye_score_b = score(o_connector_rx_port_b_eq, best_b);
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic strap(input logic [3:0] host, input logic [3:0] conn, input logic [1:0] md);
		i_enable = 1'b0;
		step(2);
		sym = {md, conn[3:2], conn[1:0], host[3:2], host[1:0]};
		i_enable = 1'b1;
		step(4);
	endtask
	// adaptation only ever started here, the only place insertion is driven and a receptacle is assumed
	task automatic adapt(input logic [1:0] md, input logic [3:0] up, input logic [3:0] off, input logic dir);
		i_reg_conn_mode = md;
		i_reg_sweep_upper_limit = up;
		i_reg_eq_offset_amount = off;
		i_reg_eq_offset_direction = dir;
		best_a = 4'($urandom_range(up));
		best_b = 4'($urandom_range(up));
		i_long_channel_a = 1'($urandom);
		i_long_channel_b = ~i_long_channel_a;
		step(3);
		i_insert_a = 1'b1;
		i_insert_b = 1'b1;
		step(1);
		i_insert_b = 1'b0;
		i_insert_a = 1'b0;
		step(2);
		i_insert_a = 1'b1;
		step(1);
		i_insert_a = 1'b0;
		chk({o_adapt_busy_a, o_adapt_busy_b}, 8'h3, "busy during search");
		for (int n = 0; n < 400 && (o_adapt_busy_a || o_adapt_busy_b); n++) step(1);
		step(2);
		chk({o_adapt_busy_a, o_adapt_busy_b}, 8'h0, "search finished in time");
		chk(o_connector_rx_port_a_eq, expect_eq(md, best_a, i_long_channel_a), "port a adapted eq");
		chk(o_connector_rx_port_b_eq, expect_eq(md, best_b, i_long_channel_b), "port b adapted eq");
	endtask
	initial begin
		void'($urandom(73));
		step(5);
		i_rst = 1'b0;
		for (int k = 0; k < 20; k++) begin
			h = k < 16 ? 4'(k) : 4'($urandom);
			c = k < 16 ? 4'(15 - k) : 4'($urandom);
			strap(h, c, k[0] ? 2'h3 : 2'h0);
			chk(o_host_side_receiver_eq, h, "host strap eq");
			chk(o_connector_rx_port_a_eq, c, "port a strap eq");
			chk(o_connector_rx_port_b_eq, c, "port b strap eq");
			chk({o_connector_eq_mode, o_straps_valid, o_strap_bias_off}, 8'h3, "strap status");
			step(6);
			chk({o_host_side_receiver_eq, o_connector_rx_port_a_eq}, {h, c}, "held eq");
		end
		i_enable = 1'b0;
		step(2);
		chk({o_host_side_receiver_eq, o_straps_valid, o_strap_bias_off}, 8'h0, "cleared on enable low");
		$display("strap test done");
		strap(4'h0, 4'h0, 2'h0);
		i_reg_mode = 1'b1;
		for (int k = 0; k < 8; k++) begin
			{i_reg_host_eq, i_reg_conn_a_eq, i_reg_conn_b_eq} = 12'($urandom);
			i_reg_conn_mode = 2'(k);
			i_reg_limited_enable = k[2];
			i_reg_preshoot = 2'(k);
			i_reg_deemphasis = ~2'(k);
			step(4);
			chk(o_host_side_receiver_eq, i_reg_host_eq, "host register eq");
			if (k[0] == k[1]) chk({o_connector_rx_port_a_eq, o_connector_rx_port_b_eq}, {i_reg_conn_a_eq, i_reg_conn_b_eq}, "conn register eq");
			chk(o_connector_eq_mode, k[1:0] == 2'h3 ? 2'h0 : 2'(k), "conn mode");
			chk({o_host_to_conn_linear, o_host_side_transmitter_limited, o_preshoot, o_deemphasis},
				{2'b11 & {1'b1, k[2]}, k[2] ? {2'(k), ~2'(k)} : 4'h0}, "transmitter mode");
		end
		$display("register test done");
		adapt(2'h2, 4'hf, 4'hf, 1'b0);
		adapt(2'h2, 4'h0, 4'h3, 1'b1);
		for (int k = 0; k < 3; k++) adapt(2'h2, 4'($urandom), 4'($urandom), 1'($urandom));
		for (int k = 0; k < 2; k++) adapt(2'h1, 4'h0, 4'h0, 1'b0);
		i_reg_mode = 1'b0;
		strap(4'h5, 4'h0, 2'h2);
		adapt(2'h2, 4'h8, 4'h0, 1'b0);
		strap(4'h5, 4'h0, 2'h1);
		adapt(2'h1, 4'h8, 4'h0, 1'b0);
		$display("adaptive test done");
		end_of_test();
	end
endmodule // tb
`default_nettype wire
